//--- int_desc_map.vh
// Register offsets, field positions and reset values of the interrupt descriptor executor
`ifndef INT_DESC_MAP_VH
`define INT_DESC_MAP_VH
// Register byte offsets
`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_TOGGLE    12'h008
`define OFF_COUNT     12'h00C
`define OFF_PAYLOAD   12'h010
`define OFF_FRAME     12'h014
`define OFF_DONE_ST   12'h018
`define OFF_IRQ_ST    12'h01C
`define OFF_IRQ_MASK  12'h020
`define OFF_BUSFRAME  12'h024
// Control word fields
`define CTRL_ACTIVE   31
`define CTRL_VALID    30
`define CTRL_HALT     29
`define CTRL_TOKEN_HI 17
`define CTRL_TOKEN_LO 16
`define CTRL_MASK_HI  7
`define CTRL_MASK_LO  0
// Toggle / error word fields
`define TOG_BIT       2
`define TOG_ERR_HI    1
`define TOG_ERR_LO    0
// Frame word fields
`define FRAME_MS_HI   7
`define FRAME_MS_LO   3
// Completion status bits
`define ST_XERR       0
`define ST_BABBLE     1
`define ST_UNDERRUN   2
// Token codes
`define TOKEN_OUT     2'b00
`define TOKEN_IN      2'b01
// Interrupt status bits
`define IRQ_DONE      0
`define IRQ_ERR       1
`define IRQ_HALT      2
// Reset values
`define RST_WORD      32'h0000_0000
`define RST_ERR       2'h0
`endif

//--- uframe_status_slot.v
// One microframe completion status slot, hardware written, cleared on restart
`timescale 1ns/10ps
`include "int_desc_map.vh"
module uframe_status_slot
(
   // Clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // Update
   input  wire       clr,
   input  wire       wr,
   input  wire [2:0] st_in,
   // Result
   output reg  [2:0] st_r
);
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_r <= 3'h0;
      else if (wr)
         st_r <= st_in;
      else if (clr)
         st_r <= 3'h0;
   end
endmodule // uframe_status_slot

//--- poll_interval_decode.v
// Decode of the millisecond polling field into an interval and a frame match
`timescale 1ns/10ps
`include "int_desc_map.vh"
module poll_interval_decode
(
   // Descriptor frame field and bus frame
   input  wire [4:0]  ms_field,
   input  wire [10:0] bus_frame,
   // Result
   output reg         frame_match,
   output reg  [8:0]  interval_uf
);
   reg [3:0] b;
   // Frame due when bus frame is a multiple of the period in milliseconds
   always @*
   begin
      b           = 4'h0;
      interval_uf = 9'h001;
      frame_match = 1'b1;
      if (ms_field == 5'h00)
         frame_match = 1'b1;
      else if (ms_field[4])
         begin
            b           = 4'h8;
            frame_match = (bus_frame[3:0] == 4'h0);
         end
      else if (ms_field[3])
         begin
            b           = 4'h7;
            frame_match = (bus_frame[2:0] == 3'h0);
         end
      else if (ms_field[2])
         begin
            b           = 4'h6;
            frame_match = (bus_frame[1:0] == 2'h0);
         end
      else if (ms_field[1])
         begin
            b           = 4'h5;
            frame_match = (bus_frame[0] == 1'b0);
         end
      else
         b = 4'h4;
      // interval is two to the b minus one
      if (b != 4'h0)
         interval_uf = 9'h001 << (b - 4'h1);
   end
endmodule // poll_interval_decode

//--- int_desc_exec.v
// Function
// - Three-bit status: error, babble, underrun
// - Eight separate hardware-written status slots
// - Issue only in enabled microframes of matching frame
// - Activation pattern selects microframe cadence
// - Software sets, hardware clears activation bits
// - Active written with the valid value unless halted
// - Software loads toggle, hardware writes next
// - Two-bit error counter, both sides write
// - Fifteen-bit count of bytes moved
// - Upper frame bits are millisecond interval
// - Interval is two to b minus one
// - Token 00 is OUT, 01 is IN
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "int_desc_map.vh"
module int_desc_exec
#(
   parameter CNT_W = 15
)
(
   // APB
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Bus timing
   input  wire        uframe_start,
   input  wire [2:0]  uframe_index,
   input  wire [10:0] bus_frame,
   // Transaction engine
   output reg         xfer_issue,
   output reg         xfer_is_in,
   output reg         xfer_toggle,
   output reg  [15:0] xfer_ram_ptr,
   input  wire        xfer_done,
   input  wire [2:0]  xfer_status,
   input  wire [CNT_W-1:0] xfer_bytes,
   input  wire        xfer_halted,
   // Interrupt
   output reg         irq
);
   localparam S_IDLE = 3'b001;
   localparam S_WAIT = 3'b010;
   localparam S_DONE = 3'b100;

   reg  [2:0]       state_r;
   reg              active_r;
   reg              valid_r;
   reg              halt_r;
   reg  [1:0]       token_r;
   reg  [7:0]       act_mask_r;
   reg              toggle_r;
   reg  [1:0]       err_r;
   reg  [CNT_W-1:0] count_r;
   reg  [15:0]      payload_r;
   reg  [7:0]       frame_r;
   reg  [2:0]       irq_st_r;
   reg  [2:0]       irq_mask_r;
   reg  [2:0]       cur_uf_r;
   reg  [7:0]       st_wr;
   reg  [2:0]       st_f;

   // Merged next values of the descriptor fields
   reg  [7:0]       act_mask_nxt;
   reg  [7:0]       uf_clr;
   reg              halt_nxt;
   reg              toggle_nxt;
   reg  [1:0]       err_nxt;
   reg  [2:0]       irq_st_nxt;
   wire [23:0]      st_all;
   wire             frame_match;
   wire [8:0]       interval_uf;

   // First access cycle launches the answer
   wire acc    = psel & penable & ~pready;
   // Writes land only at the edge that completes the access; a
   // write-one-to-clear there still wipes an event set one cycle earlier
   wire wr_en  = psel & penable & pready & pwrite;
   wire wr_ctl = wr_en && (paddr == `OFF_CTRL);
   wire wr_tog = wr_en && (paddr == `OFF_TOGGLE);
   wire wr_pay = wr_en && (paddr == `OFF_PAYLOAD);
   wire wr_frm = wr_en && (paddr == `OFF_FRAME);
   wire wr_ist = wr_en && (paddr == `OFF_IRQ_ST);
   wire wr_msk = wr_en && (paddr == `OFF_IRQ_MASK);
   // Unmapped or unaligned addresses answer with an error and read as zero
   wire mapped = (paddr <= `OFF_BUSFRAME) && (paddr[1:0] == 2'b00);

   // Restarting the descriptor wipes old per-microframe results
   wire restart = wr_ctl & pwdata[`CTRL_VALID];

   poll_interval_decode u_dec
   (
      .ms_field    (frame_r[`FRAME_MS_HI:`FRAME_MS_LO]),
      .bus_frame   (bus_frame),
      .frame_match (frame_match),
      .interval_uf (interval_uf)
   );

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_slot
         uframe_status_slot u_slot
         (
            .pclk    (pclk),
            .presetn (presetn),
            .clr     (restart),
            .wr      (st_wr[g]),
            .st_in   (st_f),
            .st_r    (st_all[3*g+2:3*g])
         );
      end
   endgenerate

   always @*
   begin
      st_wr = 8'h00;
      // slot written at the done edge, a cycle before the mask bit drops
      if (state_r == S_WAIT && xfer_done)
         st_wr[cur_uf_r] = 1'b1;
   end

   // issue only in matching frame with enabled bit
   // the mask pattern sets the microframe cadence, the frame match the frame cadence
   wire due = uframe_start && valid_r && active_r && !halt_r && frame_match
              && act_mask_r[uframe_index] && (state_r == S_IDLE);

   // Result status filtered by direction
   always @*
   begin
      st_f = 3'h0;
      // error always, babble IN only, underrun OUT only
      st_f[`ST_XERR] = xfer_status[`ST_XERR];
      if (token_r == `TOKEN_IN)
         st_f[`ST_BABBLE] = xfer_status[`ST_BABBLE];
      if (token_r == `TOKEN_OUT)
         st_f[`ST_UNDERRUN] = xfer_status[`ST_UNDERRUN];
   end

   wire bad = |st_f;

   // Descriptor fields next state; a hardware halt beats a same-cycle write
   always @*
   begin
      uf_clr       = 8'h00;
      halt_nxt     = halt_r;
      toggle_nxt   = toggle_r;
      err_nxt      = err_r;
      if (state_r == S_DONE)
         uf_clr[cur_uf_r] = 1'b1;
      // software may only set bits; only those survive a same-cycle clear
      act_mask_nxt = act_mask_r & ~uf_clr;
      if (wr_ctl)
         act_mask_nxt = act_mask_nxt | pwdata[`CTRL_MASK_HI:`CTRL_MASK_LO];
      if (state_r == S_WAIT && xfer_done)
      begin
         // next toggle only on a clean transaction
         if (!bad)
            toggle_nxt = ~toggle_r;
         if (bad && err_r != 2'h3)
            err_nxt = err_r + 2'h1;
         else if (!bad)
            err_nxt = `RST_ERR;
      end
      if (wr_tog)
      begin
         toggle_nxt = pwdata[`TOG_BIT];
         err_nxt    = pwdata[`TOG_ERR_HI:`TOG_ERR_LO];
      end
      if (wr_ctl)
         halt_nxt = pwdata[`CTRL_HALT];
      if (state_r == S_WAIT && xfer_done && xfer_halted)
         halt_nxt = 1'b1;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r      <= S_IDLE;
         active_r     <= 1'b0;
         valid_r      <= 1'b0;
         halt_r       <= 1'b0;
         token_r      <= `TOKEN_OUT;
         act_mask_r   <= 8'h00;
         toggle_r     <= 1'b0;
         err_r        <= `RST_ERR;
         count_r      <= {CNT_W{1'b0}};
         payload_r    <= 16'h0000;
         frame_r      <= 8'h00;
         cur_uf_r     <= 3'h0;
         xfer_issue   <= 1'b0;
         xfer_is_in   <= 1'b0;
         xfer_toggle  <= 1'b0;
         xfer_ram_ptr <= 16'h0000;
      end
      else
      begin
         xfer_issue <= 1'b0;
         case (state_r)
            S_IDLE:
            begin
               if (due)
               begin
                  cur_uf_r     <= uframe_index;
                  xfer_issue   <= 1'b1;
                  xfer_is_in   <= (token_r == `TOKEN_IN);
                  xfer_toggle  <= toggle_r;
                  xfer_ram_ptr <= payload_r;
                  state_r      <= S_WAIT;
               end
            end
            S_WAIT:
            begin
               if (xfer_done)
               begin
                  // Status, toggle and error take their next values above
                  // bytes moved, intermediate counts allowed
                  count_r  <= xfer_bytes;
                  state_r  <= S_DONE;
               end
            end
            S_DONE:
            begin
               active_r <= valid_r & ~halt_r;
               state_r  <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
         // Merged hardware and software updates of the descriptor fields
         act_mask_r <= act_mask_nxt;
         halt_r     <= halt_nxt;
         toggle_r   <= toggle_nxt;
         err_r      <= err_nxt;
         if (wr_ctl)
         begin
            active_r   <= pwdata[`CTRL_ACTIVE];
            valid_r    <= pwdata[`CTRL_VALID];
            token_r    <= pwdata[`CTRL_TOKEN_HI:`CTRL_TOKEN_LO];
         end
         if (wr_pay)
            payload_r <= pwdata[15:0];
         if (wr_frm)
            frame_r <= pwdata[7:0];
      end
   end

   // Interrupt status, set wins over write-one-to-clear
   wire [2:0] ev;
   // Events are single-cycle; each fires at the done edge
   assign ev[`IRQ_DONE] = (state_r == S_WAIT) & xfer_done;
   assign ev[`IRQ_ERR]  = (state_r == S_WAIT) & xfer_done & bad;
   assign ev[`IRQ_HALT] = (state_r == S_WAIT) & xfer_done & xfer_halted;
   wire [2:0] w1c = wr_ist ? pwdata[2:0] : 3'h0;

   // A clear that meets a new event leaves the event standing
   always @*
   begin
      irq_st_nxt = (irq_st_r & ~w1c) | ev;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_st_r   <= 3'h0;
         irq_mask_r <= 3'h0;
         irq        <= 1'b0;
      end
      else
      begin
         irq_st_r <= irq_st_nxt;
         if (wr_msk)
            irq_mask_r <= pwdata[2:0];
         // Built from the next status so the level adds no further lag
         irq <= |(irq_st_nxt & irq_mask_r);
      end
   end

   // APB read mux, answer in the access cycle
   reg [31:0] rd;
   always @*
   begin
      rd = `RST_WORD;
      case (paddr)
         `OFF_CTRL:
         begin
            rd[`CTRL_ACTIVE] = active_r;
            rd[`CTRL_VALID]  = valid_r;
            rd[`CTRL_HALT]   = halt_r;
            rd[`CTRL_TOKEN_HI:`CTRL_TOKEN_LO] = token_r;
            rd[`CTRL_MASK_HI:`CTRL_MASK_LO]   = act_mask_r;
         end
         `OFF_STATUS:   rd = {8'h00, st_all};
         `OFF_TOGGLE:   rd = {29'h0, toggle_r, err_r};
         `OFF_COUNT:    rd[CNT_W-1:0] = count_r;
         `OFF_PAYLOAD:  rd = {16'h0000, payload_r};
         `OFF_FRAME:    rd = {24'h0, frame_r};
         `OFF_DONE_ST:  rd = {20'h0, interval_uf, cur_uf_r};
         `OFF_IRQ_ST:   rd = {29'h0, irq_st_r};
         `OFF_IRQ_MASK: rd = {29'h0, irq_mask_r};
         `OFF_BUSFRAME: rd = {20'h0, frame_match, bus_frame};
         default:       rd = `RST_WORD;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= `RST_WORD;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // One wait state: pready rises one cycle into the access phase
         pready  <= acc;
         pslverr <= acc & ~mapped;
         if (acc & ~pwrite)
            prdata <= rd;
      end
   end
endmodule // int_desc_exec

//--- int_desc_exec_sva.sv
// Port checker of the interrupt descriptor executor
`timescale 1ns/10ps
module int_desc_exec_chk
(
   // Clock, reset and bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Engine side
   input wire logic        uframe_start,
   input wire logic        xfer_issue,
   input wire logic        xfer_is_in,
   input wire logic        xfer_toggle,
   input wire logic [15:0] xfer_ram_ptr,
   input wire logic        xfer_done,
   input wire logic        xfer_halted
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ready_slot;
      psel && $rose(penable) |=> pready;
   endproperty
   a_ready_slot: assert property (p_ready_slot) else $error("answer late");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("answer too long");
   property p_err_read;
      pslverr |-> pready && (pwrite || prdata == 32'h0000_0000);
   endproperty
   a_err_read: assert property (p_err_read) else $error("refused access wrong");
   property p_issue_pulse;
      xfer_issue |=> !xfer_issue;
   endproperty
   a_issue_pulse: assert property (p_issue_pulse) else $error("issue too long");
   property p_issue_cause;
      xfer_issue |-> $past(uframe_start);
   endproperty
   a_issue_cause: assert property (p_issue_cause) else $error("issue unprompted");
   property p_done_gap;
      xfer_done |=> !xfer_issue;
   endproperty
   a_done_gap: assert property (p_done_gap) else $error("issue after done");
   property p_hold;
      $changed({xfer_is_in, xfer_toggle, xfer_ram_ptr}) |-> xfer_issue;
   endproperty
   a_hold: assert property (p_hold) else $error("request moved");
   property p_halt_stop;
      xfer_done && xfer_halted |=> !xfer_issue [*4];
   endproperty
   a_halt_stop: assert property (p_halt_stop) else $error("issue after halt");
endmodule // int_desc_exec_chk

bind int_desc_exec int_desc_exec_chk i_int_desc_exec_chk
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .uframe_start(uframe_start),
   .xfer_issue(xfer_issue), .xfer_is_in(xfer_is_in), .xfer_toggle(xfer_toggle),
   .xfer_ram_ptr(xfer_ram_ptr), .xfer_done(xfer_done), .xfer_halted(xfer_halted)
);

//--- usb_int_endpoint.sv
// Behavioural interrupt endpoint answering the transaction engine
`timescale 1ns/10ps
module usb_int_endpoint
#(
   parameter CNT_W = 15
)
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Engine request
   input  wire logic             xfer_issue,
   input  wire logic             xfer_is_in,
   // Answer chosen by the bench
   input  wire logic [3:0]       resp_delay,
   input  wire logic [2:0]       resp_status,
   input  wire logic [CNT_W-1:0] resp_bytes,
   input  wire logic             resp_halt,
   // Answer to the engine
   output logic                  xfer_done,
   output logic [2:0]            xfer_status,
   output logic [CNT_W-1:0]      xfer_bytes,
   output logic                  xfer_halted
);
   logic [4:0] wait_r;
   logic       dir_in_r;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wait_r <= 5'h00;
         dir_in_r <= 1'b0;
         xfer_done <= 1'b0;
         xfer_status <= 3'h0;
         xfer_bytes <= '0;
         xfer_halted <= 1'b0;
      end
      else if (xfer_issue)
      begin
         wait_r <= {1'b0, resp_delay} + 5'h01;
         dir_in_r <= xfer_is_in;
         xfer_done <= 1'b0;
      end
      else if (wait_r == 5'h01)
      begin
         wait_r <= 5'h00;
         xfer_done <= 1'b1;
         // babble on IN only, underrun on OUT only
         xfer_status <= resp_status & (dir_in_r ? 3'b011 : 3'b101);
         xfer_bytes <= resp_bytes;
         xfer_halted <= resp_halt;
      end
      else
      begin
         wait_r <= (wait_r == 5'h00) ? 5'h00 : wait_r - 5'h01;
         xfer_done <= 1'b0;
         // Stale answers flip so they never pass for valid ones
         xfer_status <= ~xfer_status;
         xfer_bytes <= ~xfer_bytes;
         xfer_halted <= ~xfer_halted;
      end
   end
endmodule // usb_int_endpoint

//--- int_desc_exec_test.sv
// Self-checking bench of the interrupt descriptor executor
`timescale 1ns/10ps
`include "int_desc_map.vh"
module int_desc_exec_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        uframe_start = 1'b0;
   logic [2:0]  uframe_index = 3'h0;
   logic [10:0] bus_frame = 11'h000;
   logic [3:0]  resp_delay = 4'h0;
   logic [2:0]  resp_status = 3'h0;
   logic [14:0] resp_bytes = 15'h0000;
   logic        resp_halt = 1'b0;
   logic [31:0] prdata, rd, r;
   logic [15:0] xfer_ram_ptr, ptr;
   logic [14:0] xfer_bytes;
   logic [23:0] exp_st;
   logic [10:0] f;
   logic [7:0]  m;
   logic [2:0]  xfer_status, s;
   logic [1:0]  err;
   logic        pready, pslverr, xfer_issue, xfer_is_in, xfer_toggle;
   logic        xfer_done, xfer_halted, irq, er, hit, got, tin, tog;
   integer      failures = 0;
   integer      cmp_count = 0;
   integer      seed = 32'h179DACDE;
   integer      n, i, k, p;
   always #5 pclk = ~pclk;
   int_desc_exec #(.CNT_W(15)) i_int_desc_exec
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .uframe_start(uframe_start), .uframe_index(uframe_index), .bus_frame(bus_frame),
      .xfer_issue(xfer_issue), .xfer_is_in(xfer_is_in), .xfer_toggle(xfer_toggle),
      .xfer_ram_ptr(xfer_ram_ptr), .xfer_done(xfer_done), .xfer_status(xfer_status),
      .xfer_bytes(xfer_bytes), .xfer_halted(xfer_halted), .irq(irq)
   );
   usb_int_endpoint #(.CNT_W(15)) i_usb_int_endpoint
   (
      .pclk(pclk), .presetn(presetn), .xfer_issue(xfer_issue), .xfer_is_in(xfer_is_in),
      .resp_delay(resp_delay), .resp_status(resp_status), .resp_bytes(resp_bytes),
      .resp_halt(resp_halt), .xfer_done(xfer_done), .xfer_status(xfer_status),
      .xfer_bytes(xfer_bytes), .xfer_halted(xfer_halted)
   );
   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n = n + 1;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         failures = failures + 1;
         final_report;
      end
   endtask
   // Start one microframe and let any transaction it launches finish
   task uframe(input logic [2:0] idx);
      @(posedge pclk);
      r = $random(seed);
      uframe_start <= 1'b1;
      uframe_index <= idx;
      resp_delay <= r[3:0];
      resp_status <= r[4] ? r[7:5] : 3'h0;
      resp_bytes <= r[22:8];
      @(posedge pclk);
      uframe_start <= 1'b0;
      hit = 1'b0;
      got = 1'b0;
      n = 0;
      while (n < 40 && !got && (hit || n < 4))
      begin
         @(posedge pclk);
         n = n + 1;
         if (xfer_issue === 1'b1)
            hit = 1'b1;
         if (xfer_done === 1'b1)
            got = 1'b1;
      end
      if (hit && !got)
      begin
         failures = failures + 1;
         final_report;
      end
      repeat (3) @(posedge pclk);
   endtask
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFF_CTRL, 32'h0);
      check(rd, `RST_WORD);
      apb(1'b0, 12'hFFC, 32'h0);
      check({31'h0, er}, 32'h1);
      check(rd, `RST_WORD);
      for (k = 0; k < 5; k = k + 1)
      begin
         r = $random(seed);
         f = r[11] ? r[10:0] << k : r[10:0];
         bus_frame <= f;
         apb(1'b1, `OFF_FRAME, 32'h8 << k);
         apb(1'b0, `OFF_DONE_ST, 32'h0);
         check(rd[11:3], 9'h8 << k);
         apb(1'b0, `OFF_BUSFRAME, 32'h0);
         check(rd[11:0], {(f % (11'h1 << k)) == 11'h0, f});
      end
      apb(1'b1, `OFF_FRAME, 32'h0);
      for (p = 0; p < 4; p = p + 1)
      begin
         r = $random(seed);
         m = (p == 0) ? 8'h11 : (p == 1) ? 8'h55 : (p == 2) ? 8'hFF : r[7:0];
         tin = p[0];
         tog = r[8];
         ptr = r[31:16];
         err = 2'h0;
         exp_st = 24'h0;
         apb(1'b1, `OFF_PAYLOAD, {16'h0, ptr});
         apb(1'b1, `OFF_TOGGLE, {29'h0, tog, 2'h0});
         apb(1'b1, `OFF_IRQ_MASK, (p == 3) ? 32'h0 : 32'h7);
         apb(1'b1, `OFF_CTRL, {2'b11, 12'h0, 1'b0, tin, 8'h0, m});
         for (i = 0; i < 8; i = i + 1)
         begin
            uframe(i[2:0]);
            check(hit, m[i]);
            if (hit)
            begin
               check({xfer_is_in, xfer_toggle, xfer_ram_ptr}, {tin, tog, ptr});
               s = resp_status & (tin ? 3'b011 : 3'b101);
               exp_st[3*i +: 3] = s;
               tog = (s == 3'h0) ? ~tog : tog;
               err = (s == 3'h0) ? 2'h0 : (err == 2'h3) ? err : err + 2'h1;
               check(irq, p != 3);
               apb(1'b0, `OFF_COUNT, 32'h0);
               check(rd, {17'h0, resp_bytes});
               apb(1'b0, `OFF_TOGGLE, 32'h0);
               check(rd, {29'h0, tog, err});
               apb(1'b0, `OFF_IRQ_ST, 32'h0);
               check(rd, {29'h0, 1'b0, s != 3'h0, 1'b1});
               apb(1'b1, `OFF_IRQ_ST, 32'h7);
               apb(1'b0, `OFF_IRQ_ST, 32'h0);
               check(irq, 1'b0);
            end
         end
         apb(1'b0, `OFF_CTRL, 32'h0);
         check({rd[31:30], rd[7:0]}, 10'h300);
         apb(1'b0, `OFF_STATUS, 32'h0);
         check(rd, {8'h0, exp_st});
      end
      resp_halt <= 1'b1;
      apb(1'b1, `OFF_CTRL, 32'hC000_00FF);
      uframe(3'h0);
      check(hit, 1'b1);
      uframe(3'h1);
      check(hit, 1'b0);
      apb(1'b0, `OFF_CTRL, 32'h0);
      check(rd[29], 1'b1);
      apb(1'b0, `OFF_IRQ_ST, 32'h0);
      check(rd[2], 1'b1);
      final_report;
   end
endmodule // int_desc_exec_test
